// ===== verification/gate_drive_model.sv
// Far side: a gate driver that counts output transitions.
// Assumes both drive inputs are levels synchronous to clk.
`timescale 1ns/10ps
module gate_drive_model (
	// Clock
	input  wire logic clk,
	// Drive levels
	input  wire logic drive_a,
	input  wire logic drive_b,
	// Transition count
	output int        edges
);
	logic last_a = 1'b0;
	logic last_b = 1'b0;
	initial edges = 0;
	always @(posedge clk) begin
		edges <= edges + int'(drive_a != last_a) + int'(drive_b != last_b);
		last_a <= drive_a;
		last_b <= drive_b;
	end
endmodule

// ===== verification/pwm_action_checker.sv
// Checker for the PWM action block, bound to its top module.
// Assumes one clock domain and a bus master that answers late.
`timescale 1ns/10ps
module pwm_action_checker (
	// Clock, reset and events
	input wire logic        CLK, NRST, ZERO_EVENT, LOAD_EVENT,
	input wire logic        CMP_A_UP_EVENT, CMP_A_DOWN_EVENT,
	input wire logic        CMP_B_UP_EVENT, CMP_B_DOWN_EVENT,
	// Outputs
	input wire logic        FIRST_OUTPUT_SIGNAL, SECOND_OUTPUT_SIGNAL,
	// Register bus
	input wire logic        AWVALID, AWREADY, BVALID, BREADY,
	input wire logic        ARVALID, ARREADY, RVALID, RREADY,
	input wire logic [1:0]  BRESP, RRESP,
	input wire logic [7:0]  ARADDR,
	input wire logic [31:0] RDATA
);
	// ********
	// Properties
	// ********
	wire logic idle = !(ZERO_EVENT | LOAD_EVENT | CMP_A_UP_EVENT |
		CMP_A_DOWN_EVENT | CMP_B_UP_EVENT | CMP_B_DOWN_EVENT);
	wire logic bad_addr = ARADDR > 8'h70 || ARADDR < 8'h60 ||
		ARADDR[1:0] != 2'h0;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);

	AST_HOLD:
		assert property (idle |=> $stable(FIRST_OUTPUT_SIGNAL) &&
			$stable(SECOND_OUTPUT_SIGNAL)) else $error("output moved");
	AST_RESET_LOW:
		assert property ($rose(NRST) |-> !FIRST_OUTPUT_SIGNAL &&
			!SECOND_OUTPUT_SIGNAL) else $error("output high after reset");
	AST_B_STANDS:
		assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped");
	AST_R_STANDS:
		assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data dropped");
	AST_R_ANSWER:
		assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read not answered");
	AST_W_ANSWER:
		assert property (AWVALID && AWREADY |-> ##[1:3] BVALID)
		else $error("write not answered");
	AST_AR_BLOCKED:
		assert property (RVALID |-> !ARREADY)
		else $error("read taken while busy");
	AST_R_SLVERR:
		assert property (ARVALID && ARREADY && bad_addr |=>
			RRESP == pwm_action_pkg::RESP_SLVERR && RDATA == 32'h0)
		else $error("unmapped read not refused");

	cover property (ZERO_EVENT && CMP_A_DOWN_EVENT);
	cover property (CMP_A_UP_EVENT && CMP_B_UP_EVENT);
	cover property (BVALID && BRESP == pwm_action_pkg::RESP_SLVERR);
endmodule

bind pwm_output_action_control pwm_action_checker i_chk (.*);

// ===== verification/tb_top.sv
// Testbench: random events checked against an integer model.
// Assumes the design answers each bus request; a watchdog ends hangs.
`timescale 1ns/10ps
module tb_top;
	localparam logic [7:0] A0 = pwm_action_pkg::GEN_A_ACTIONS_OFFSET;
	localparam logic [7:0] CTL = pwm_action_pkg::GEN_CONTROL_OFFSET;
	logic        clk = 0, nrst = 0, sreq = 0;
	logic [5:0]  ev = '0;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, d;
	logic [3:0]  wstrb = '0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [1:0]  r, pend, arm;
	logic [11:0] act [2], pv [2];
	logic [2:0]  ctl;
	logic        oa, ob;
	int          bad_count = 0, check_count = 0, cyc = 0, n_edges;
	wire logic   out_a, out_b, awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;

	always #2.5 clk = ~clk;
	pwm_output_action_control i_dut (.CLK(clk), .NRST(nrst),
		.ZERO_EVENT(ev[0]), .LOAD_EVENT(ev[1]), .CMP_A_UP_EVENT(ev[2]),
		.CMP_A_DOWN_EVENT(ev[3]), .CMP_B_UP_EVENT(ev[4]),
		.CMP_B_DOWN_EVENT(ev[5]), .SYNC_UPDATE_REQ(sreq),
		.FIRST_OUTPUT_SIGNAL(out_a), .SECOND_OUTPUT_SIGNAL(out_b),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
	gate_drive_model i_load (.clk(clk), .drive_a(out_a), .drive_b(out_b),
		.edges(n_edges));

	// ********
	// Reference model
	// ********
	function automatic logic nxt(logic o, logic [11:0] s, logic [5:0] e,
		bit sec);
		logic [1:0] c;
		int         k;
		c = 2'h0;
		for (int i = 5; i >= 0; i--) begin
			k = (sec && i > 1) ? i ^ 6 : i;
			if (e[k]) c = s[2 * k +: 2];
		end
		case (c)
			2'h1: return ~o;
			2'h2: return 1'b0;
			2'h3: return 1'b1;
			default: return o;
		endcase
	endfunction

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			act = '{default: 12'h0};
			pv = '{default: 12'h0};
			pend = '0;
			arm = '0;
			ctl = '0;
			oa = 1'b0;
			ob = 1'b0;
		end else begin
			oa = nxt(oa, act[0], ev & {1'b1, ctl[0], 1'b1, ctl[0], 2'h3}, 0);
			ob = nxt(ob, act[1], ev & {1'b1, ctl[0], 1'b1, ctl[0], 2'h3}, 1);
			for (int j = 0; j < 2; j++) begin
				if (sreq) arm[j] = arm[j] | pend[j];
				if (ev[0] && (ctl[j + 1] ? arm[j] : pend[j])) begin
					act[j] = pv[j];
					pend[j] = 1'b0;
					arm[j] = 1'b0;
				end
			end
		end
	end

	// ********
	// Tasks
	// ********
	task automatic chk(input string nm, input logic [31:0] s, x);
		check_count++;
		if (s !== x) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s, output logic [1:0] rs);
		logic [11:0] m;
		logic        ga, gw, gb;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ga = awvalid && awready;
			gw = wvalid && wready;
			gb = bvalid;
			rs = bresp;
			@(posedge clk);
			if (ga) awvalid <= 1'b0;
			if (gw) wvalid <= 1'b0;
		end while (!gb);
		bready <= 1'b0;
		if (a == 8'h6c && s[0] && v[0]) arm = arm | pend;
		m = {{4{s[1]}}, {8{s[0]}}};
		for (int j = 0; j < 2; j++) begin
			if (a == A0 + 8'(4 * j)) begin
				pv[j] = (pv[j] & ~m) | (v[11:0] & m);
				pend[j] = 1'b1;
			end
		end
		if (a == CTL) ctl = v[2:0];
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		logic g, t;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			g = arvalid && arready;
			t = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge clk);
			if (g) arvalid <= 1'b0;
		end while (!t);
		rready <= 1'b0;
	endtask

	// Zero and load never coincide; each comparator fires in one direction
	task automatic run(input int n, input bit s);
		logic [8:0] x;
		repeat (n) begin
			@(posedge clk);
			x = 9'($urandom);
			ev[0] <= &x[2:0];
			ev[1] <= !(&x[2:0]) && &x[4:3];
			ev[3:2] <= x[5] ? {1'b0, x[6]} : {x[6], 1'b0};
			ev[5:4] <= x[5] ? {1'b0, x[7]} : {x[7], 1'b0};
			sreq <= s && x[8] && !(&x[2:0]);
		end
		@(posedge clk);
		ev <= '0;
		sreq <= 1'b0;
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ********
	// Checks and sequence
	// ********
	always @(negedge clk) begin
		if (nrst) begin
			chk("first out", out_a, oa);
			chk("second out", out_b, ob);
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up;
		end
	end

	initial begin
		void'($urandom(32'h13724b04));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		for (int j = 0; j < 3; j++) begin
			rd(A0 + 8'(4 * j), d, r);
			chk("reset value", d, 32'h0);
		end
		rd(8'h7c, d, r);
		chk("unmapped rresp", 32'(r), 32'(pwm_action_pkg::RESP_SLVERR));
		wr(8'h80, 32'h1, 4'hf, r);
		chk("unmapped bresp", 32'(r), 32'(pwm_action_pkg::RESP_SLVERR));
		for (int k = 0; k < 8; k++) begin
			wr(CTL, 32'(k), 4'hf, r);
			repeat (2) wr(A0, $urandom, 4'h1 | 4'($urandom), r);
			wr(A0 + 8'h4, $urandom, 4'h1 | 4'($urandom), r);
			if (k[0]) wr(8'h6c, 32'h1, 4'h1, r);
			chk("write resp", 32'(r), 32'(pwm_action_pkg::RESP_OKAY));
			for (int j = 0; j < 2; j++) begin
				rd(A0 + 8'(4 * j), d, r);
				chk("actions", d, {20'h0, pv[j]});
			end
			run(80, &k[2:1]);
			rd(pwm_action_pkg::STATUS_OFFSET, d, r);
			chk("status", 32'(d[1:0]), 32'({ob, oa}));
			$display("round %0d done, %0d output edges", k, n_edges);
		end
		wrap_up;
	end
endmodule

// ===== verilog/action_if.sv
// Interface carrying counter events and action setting to one output stage.
// Assumes the events are single-cycle pulses synchronous to the clock.
`timescale 1ns/10ps
interface action_if;
	logic        ev_zero;
	logic        ev_load;
	logic        ev_a_up;
	logic        ev_a_down;
	logic        ev_b_up;
	logic        ev_b_down;
	logic        up_down;
	logic        b_wins;
	logic [11:0] actions;
	logic        level;

	modport ctrl (output ev_zero, ev_load, ev_a_up, ev_a_down, ev_b_up,
		ev_b_down, up_down, b_wins, actions, input level);
	modport stage (input ev_zero, ev_load, ev_a_up, ev_a_down, ev_b_up,
		ev_b_down, up_down, b_wins, actions, output level);
endinterface

// ===== verilog/pwm_action_pkg.sv
// Constants for the PWM output action block: register map, fields, codes.
// Assumes an AXI4-Lite register bus with 32-bit data.
package pwm_action_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0]  GEN_A_ACTIONS_OFFSET = 8'h60;
	localparam logic [7:0]  GEN_B_ACTIONS_OFFSET = 8'h64;
	localparam logic [7:0]  GEN_CONTROL_OFFSET   = 8'h68;
	localparam logic [7:0]  SYNC_REQUEST_OFFSET  = 8'h6c;
	localparam logic [7:0]  STATUS_OFFSET        = 8'h70;
	localparam logic [11:0] ACTIONS_RESET        = 12'h000;

	// ****************************************************************
	// Fields of the action registers
	// ****************************************************************
	localparam int ACTIONS_WIDTH  = 12;
	localparam int ZERO_LSB       = 0;
	localparam int LOAD_LSB       = 2;
	localparam int CMP_A_RISE_LSB = 4;
	localparam int CMP_A_FALL_LSB = 6;
	localparam int CMP_B_RISE_LSB = 8;
	localparam int CMP_B_FALL_LSB = 10;

	// ****************************************************************
	// Fields of the control register
	// ****************************************************************
	localparam int MODE_BIT       = 0;
	localparam int UPD_A_BIT      = 1;
	localparam int UPD_B_BIT      = 2;
	localparam logic UPD_SYNC     = 1'b1;
	localparam logic MODE_UP_DOWN = 1'b1;

	// ****************************************************************
	// AXI responses
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Action codes
	typedef enum logic [1:0] {
		ACT_NONE   = 2'h0,
		ACT_INVERT = 2'h1,
		ACT_LOW    = 2'h2,
		ACT_HIGH   = 2'h3
	} action_e;

endpackage

// ===== verilog/pwm_output_action_control.sv
// Action logic of one PWM generator with its AXI4-Lite register slave.
// Assumes counter event pulses and sync request arrive on CLK.
`timescale 1ns/10ps
module pwm_output_action_control (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        NRST,
	// Counter and comparator events
	input  wire logic        ZERO_EVENT,
	input  wire logic        LOAD_EVENT,
	input  wire logic        CMP_A_UP_EVENT,
	input  wire logic        CMP_A_DOWN_EVENT,
	input  wire logic        CMP_B_UP_EVENT,
	input  wire logic        CMP_B_DOWN_EVENT,
	// Synchronous update request from master control
	input  wire logic        SYNC_UPDATE_REQ,
	// Outputs
	output logic             FIRST_OUTPUT_SIGNAL,
	output logic             SECOND_OUTPUT_SIGNAL,
	// AXI4-Lite write address
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	// AXI4-Lite write data
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	// AXI4-Lite write response
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	// AXI4-Lite read address
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	// AXI4-Lite read data
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY
);
	localparam int AW = pwm_action_pkg::ACTIONS_WIDTH;

	typedef struct packed {
		logic [AW-1:0] a_written_reg;
		logic [AW-1:0] b_written_reg;
		logic [AW-1:0] a_active_reg;
		logic [AW-1:0] b_active_reg;
		logic          a_pending_reg;
		logic          b_pending_reg;
		logic          a_armed_reg;
		logic          b_armed_reg;
		logic [2:0]    control_reg;
		logic          aw_held_reg;
		logic [7:0]    awaddr_reg;
		logic          w_held_reg;
		logic [31:0]   wdata_reg;
		logic [3:0]    wstrb_reg;
		logic          bvalid_reg;
		logic [1:0]    bresp_reg;
		logic          rvalid_reg;
		logic [1:0]    rresp_reg;
		logic [31:0]   rdata_reg;
	} state_s;

	state_s state_reg;
	state_s state_next;

	action_if first_if ();
	action_if second_if ();

	// ****************************************************************
	// Register slave and update control
	// ****************************************************************
	always_comb begin
		logic        do_write;
		logic [31:0] merged;
		logic [31:0] old;
		state_next = state_reg;
		do_write = 1'b0;
		merged = '0;
		old = '0;

		if (AWVALID && !state_reg.aw_held_reg) begin
			state_next.aw_held_reg = 1'b1;
			state_next.awaddr_reg = AWADDR;
		end
		if (WVALID && !state_reg.w_held_reg) begin
			state_next.w_held_reg = 1'b1;
			state_next.wdata_reg = WDATA;
			state_next.wstrb_reg = WSTRB;
		end
		if (state_reg.bvalid_reg && BREADY) begin
			state_next.bvalid_reg = 1'b0;
		end
		if (state_reg.aw_held_reg && state_reg.w_held_reg
				&& !state_reg.bvalid_reg) begin
			do_write = 1'b1;
			state_next.aw_held_reg = 1'b0;
			state_next.w_held_reg = 1'b0;
			state_next.bvalid_reg = 1'b1;
			state_next.bresp_reg = pwm_action_pkg::RESP_OKAY;
		end

		// Synchronous request arms pending updates
		if (SYNC_UPDATE_REQ) begin
			state_next.a_armed_reg = state_reg.a_pending_reg;
			state_next.b_armed_reg = state_reg.b_pending_reg;
		end

		// Zero event commits pending settings per update mode
		if (ZERO_EVENT) begin
			if (state_reg.a_pending_reg && (state_reg.control_reg[
					pwm_action_pkg::UPD_A_BIT] != pwm_action_pkg::UPD_SYNC
					|| state_reg.a_armed_reg)) begin
				state_next.a_active_reg = state_reg.a_written_reg;
				state_next.a_pending_reg = 1'b0;
				state_next.a_armed_reg = 1'b0;
			end
			if (state_reg.b_pending_reg && (state_reg.control_reg[
					pwm_action_pkg::UPD_B_BIT] != pwm_action_pkg::UPD_SYNC
					|| state_reg.b_armed_reg)) begin
				state_next.b_active_reg = state_reg.b_written_reg;
				state_next.b_pending_reg = 1'b0;
				state_next.b_armed_reg = 1'b0;
			end
		end

		if (do_write) begin
			unique case (state_reg.awaddr_reg)
				pwm_action_pkg::GEN_A_ACTIONS_OFFSET:
					old = 32'(state_reg.a_written_reg);
				pwm_action_pkg::GEN_B_ACTIONS_OFFSET:
					old = 32'(state_reg.b_written_reg);
				pwm_action_pkg::GEN_CONTROL_OFFSET:
					old = 32'(state_reg.control_reg);
				default:
					old = '0;
			endcase
			for (int i = 0; i < 4; i++) begin
				merged[i*8 +: 8] = state_reg.wstrb_reg[i]
					? state_reg.wdata_reg[i*8 +: 8] : old[i*8 +: 8];
			end
			unique case (state_reg.awaddr_reg)
				pwm_action_pkg::GEN_A_ACTIONS_OFFSET: begin
					// Latest write replaces any pending value
					state_next.a_written_reg = merged[AW-1:0];
					state_next.a_pending_reg = 1'b1;
				end
				pwm_action_pkg::GEN_B_ACTIONS_OFFSET: begin
					state_next.b_written_reg = merged[AW-1:0];
					state_next.b_pending_reg = 1'b1;
				end
				pwm_action_pkg::GEN_CONTROL_OFFSET:
					state_next.control_reg = merged[2:0];
				pwm_action_pkg::SYNC_REQUEST_OFFSET: begin
					if (state_reg.wstrb_reg[0] && state_reg.wdata_reg[0]) begin
						state_next.a_armed_reg = state_next.a_pending_reg;
						state_next.b_armed_reg = state_next.b_pending_reg;
					end
				end
				default:
					state_next.bresp_reg = pwm_action_pkg::RESP_SLVERR;
			endcase
		end

		// Read channel
		if (state_reg.rvalid_reg && RREADY) begin
			state_next.rvalid_reg = 1'b0;
		end
		if (ARVALID && !state_reg.rvalid_reg) begin
			state_next.rvalid_reg = 1'b1;
			state_next.rresp_reg = pwm_action_pkg::RESP_OKAY;
			unique case (ARADDR)
				pwm_action_pkg::GEN_A_ACTIONS_OFFSET:
					state_next.rdata_reg = 32'(state_reg.a_written_reg);
				pwm_action_pkg::GEN_B_ACTIONS_OFFSET:
					state_next.rdata_reg = 32'(state_reg.b_written_reg);
				pwm_action_pkg::GEN_CONTROL_OFFSET:
					state_next.rdata_reg = 32'(state_reg.control_reg);
				pwm_action_pkg::SYNC_REQUEST_OFFSET:
					state_next.rdata_reg = '0;
				pwm_action_pkg::STATUS_OFFSET:
					state_next.rdata_reg = 32'({state_reg.b_armed_reg,
						state_reg.a_armed_reg, state_reg.b_pending_reg,
						state_reg.a_pending_reg, SECOND_OUTPUT_SIGNAL,
						FIRST_OUTPUT_SIGNAL});
				default: begin
					state_next.rdata_reg = '0;
					state_next.rresp_reg = pwm_action_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************************************
	// Output stages
	// ****************************************************************
	always_comb begin
		first_if.ev_zero   = ZERO_EVENT;
		first_if.ev_load   = LOAD_EVENT;
		first_if.ev_a_up   = CMP_A_UP_EVENT;
		first_if.ev_a_down = CMP_A_DOWN_EVENT;
		first_if.ev_b_up   = CMP_B_UP_EVENT;
		first_if.ev_b_down = CMP_B_DOWN_EVENT;
		first_if.up_down   = state_reg.control_reg[pwm_action_pkg::MODE_BIT]
			== pwm_action_pkg::MODE_UP_DOWN;
		first_if.b_wins    = 1'b0;
		first_if.actions   = state_reg.a_active_reg;
		second_if.ev_zero   = ZERO_EVENT;
		second_if.ev_load   = LOAD_EVENT;
		second_if.ev_a_up   = CMP_A_UP_EVENT;
		second_if.ev_a_down = CMP_A_DOWN_EVENT;
		second_if.ev_b_up   = CMP_B_UP_EVENT;
		second_if.ev_b_down = CMP_B_DOWN_EVENT;
		second_if.up_down   = first_if.up_down;
		second_if.b_wins    = 1'b1;
		second_if.actions   = state_reg.b_active_reg;
	end

	pwm_output_stage first_stage (
		.CLK  (CLK),
		.NRST (NRST),
		.act  (first_if.stage)
	);

	pwm_output_stage second_stage (
		.CLK  (CLK),
		.NRST (NRST),
		.act  (second_if.stage)
	);

	assign FIRST_OUTPUT_SIGNAL  = first_if.level;
	assign SECOND_OUTPUT_SIGNAL = second_if.level;

	assign AWREADY = !state_reg.aw_held_reg;
	assign WREADY  = !state_reg.w_held_reg;
	assign BVALID  = state_reg.bvalid_reg;
	assign BRESP   = state_reg.bresp_reg;
	assign ARREADY = !state_reg.rvalid_reg;
	assign RVALID  = state_reg.rvalid_reg;
	assign RRESP   = state_reg.rresp_reg;
	assign RDATA   = state_reg.rdata_reg;
endmodule

// ===== verilog/pwm_output_stage.sv
// One output signal: resolves coincident events and applies the action.
// Assumes action settings are already the effective (updated) values.
`timescale 1ns/10ps
module pwm_output_stage (
	// Clock and reset
	input  wire logic CLK,
	input  wire logic NRST,
	// Events and settings
	action_if.stage   act
);
	typedef struct packed {
		logic level_reg;
	} state_s;

	state_s state_reg;
	state_s state_next;

	function automatic logic [1:0] field(input logic [11:0] v, input int lsb);
		field = v[lsb +: 2];
	endfunction

	// ****************************************************************
	// Event priority and action decode
	// ****************************************************************
	always_comb begin
		logic        a_hit;
		logic        b_hit;
		logic [1:0]  code;
		a_hit = act.ev_a_down | (act.up_down & act.ev_a_up);
		b_hit = act.ev_b_down | (act.up_down & act.ev_b_up);
		code = pwm_action_pkg::ACT_NONE;
		if (act.ev_zero) begin
			code = field(act.actions, pwm_action_pkg::ZERO_LSB);
		end else if (act.ev_load) begin
			code = field(act.actions, pwm_action_pkg::LOAD_LSB);
		end else if (a_hit && (!b_hit || !act.b_wins)) begin
			code = act.ev_a_down ? field(act.actions, pwm_action_pkg::CMP_A_FALL_LSB)
				: field(act.actions, pwm_action_pkg::CMP_A_RISE_LSB);
		end else if (b_hit) begin
			code = act.ev_b_down ? field(act.actions, pwm_action_pkg::CMP_B_FALL_LSB)
				: field(act.actions, pwm_action_pkg::CMP_B_RISE_LSB);
		end
		state_next = state_reg;
		unique case (pwm_action_pkg::action_e'(code))
			pwm_action_pkg::ACT_NONE:   state_next.level_reg = state_reg.level_reg;
			pwm_action_pkg::ACT_INVERT: state_next.level_reg = ~state_reg.level_reg;
			pwm_action_pkg::ACT_LOW:    state_next.level_reg = 1'b0;
			pwm_action_pkg::ACT_HIGH:   state_next.level_reg = 1'b1;
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign act.level = state_reg.level_reg;
endmodule
